// file: hdl/index_addr_pkg.sv
// package: constants, register map and carrier types of the indexed address generator
// assumes: one 250 MHz clock, registers reached over AHB-Lite with 32-bit data
package index_addr_pkg;

  // ==========================================================
  // sizes
  localparam int ADDR_W = 7;
  localparam int MEM_WORDS = 128;
  localparam int RESULT_W = 16;

  // ==========================================================
  // register map, byte addresses
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] ITER_MOD_OFS = 32'h0000_0004;
  localparam logic [31:0] SAMPLE_MOD_OFS = 32'h0000_0008;
  localparam logic [31:0] STATUS_OFS = 32'h0000_000c;

  // field positions
  localparam int CTRL_PTR_MODE_BIT = 0;
  localparam int STATUS_SAMPLE_LSB = 0;
  localparam int STATUS_PTR_MODE_BIT = 8;

  // values after reset
  localparam logic CTRL_PTR_MODE_RST = 1'b0;
  localparam logic [ADDR_W-1:0] MOD_RST = 7'h00;
  localparam logic [ADDR_W-1:0] INDEX_RST = 7'h00;

  // ==========================================================
  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    REG_NONE = 2'h0,
    REG_CTRL = 2'h1,
    REG_ITER_MOD = 2'h3,
    REG_SAMPLE_MOD = 2'h2
  } reg_sel_t;

  typedef enum logic {
    SEL_ITERATION = 1'b0,
    SEL_SAMPLE = 1'b1
  } index_sel_t;

  // address field and addressing mode of the current microcode word
  typedef struct packed {
    logic valid;
    logic indexed;
    index_sel_t sel;
    logic shared;
    logic in_subprog;
    logic [ADDR_W-1:0] addr_field;
  } ucode_t;

  // sequencer and program strobes steering the two index registers
  typedef struct packed {
    logic iter_step;
    logic sample_start;
    logic sample_load;
  } index_ctl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] count;
  } cnt_state_t;

  typedef struct packed {
    logic ptr_mode;
    logic [ADDR_W-1:0] iter_mod;
    logic [ADDR_W-1:0] sample_mod;
    logic wr_pend;
    reg_sel_t wr_sel;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [ADDR_W-1:0] mem_addr;
    logic mem_valid;
    logic index_fault;
  } top_state_t;

endpackage

// file: hdl/mod_index_counter.sv
// holds: one index register, counting modulo a set value or loaded in parallel
// assumes: synchronous reset, clock enable freezes the count
`timescale 1ns/1ns
module mod_index_counter #(
  parameter int WIDTH = 7
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic step,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic [WIDTH-1:0] modulus,
  output logic [WIDTH-1:0] count
);

  // ==========================================================
  // next value: load wins over step, wrap at modulus minus one
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] last;

  always_comb begin
    last = WIDTH'(modulus - 1'b1);
    count_d = count_q;
    if (load) begin
      count_d = load_value;
    end else if (step) begin
      count_d = (count_q == last) ? '0 : WIDTH'(count_q + 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_q <= '0;
    end else if (clk_en) begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule

// file: hdl/indexed_address_generator.sv
// What this block does
// - direct access: address field passes unchanged to the data-memory address
// - indexed access: address is address field plus the selected index register
// - iteration index advances once per executed sub-program iteration
// - iteration index wraps at its set modulus, its only setting
// - iteration index is neither written nor read by the program
// - counter mode: sample index counts modulo its set value, wrapping to zero
// - counter mode: sample index steps once at each new sample period start
// - pointer mode: sample index loads from the result bus on command, else holds
// - generated addresses cover at most 128 memory locations
// - both index registers are presented to the decision state machine
// - shared arrays use iteration index in sub-program, sample index in main
// - sample-index use on shared arrays only allowed in counter mode
//
// file: top of the address-arithmetic unit with its AHB-Lite register slave
// assumes: single clock, synchronous active-high reset, one AHB-Lite master
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
module indexed_address_generator #(
  parameter int ADDR_W = index_addr_pkg::ADDR_W,
  parameter int RESULT_W = index_addr_pkg::RESULT_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire index_addr_pkg::ucode_t ucode,
  input wire index_addr_pkg::index_ctl_t index_ctl,
  input wire logic [RESULT_W-1:0] result_bus,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_addr_valid,
  output logic index_fault,
  output logic [ADDR_W-1:0] iteration_index,
  output logic [ADDR_W-1:0] sample_index
);

  // ==========================================================
  // register decode
  function automatic index_addr_pkg::reg_sel_t decode_reg(input logic [31:0] a);
    if (a == index_addr_pkg::CTRL_OFS) begin
      return index_addr_pkg::REG_CTRL;
    end else if (a == index_addr_pkg::ITER_MOD_OFS) begin
      return index_addr_pkg::REG_ITER_MOD;
    end else if (a == index_addr_pkg::SAMPLE_MOD_OFS) begin
      return index_addr_pkg::REG_SAMPLE_MOD;
    end else begin
      return index_addr_pkg::REG_NONE;
    end
  endfunction

  index_addr_pkg::top_state_t st_q;
  index_addr_pkg::top_state_t st_d;
  logic [ADDR_W-1:0] iter_cnt;
  logic [ADDR_W-1:0] sample_cnt;
  logic bus_take;
  logic [31:0] rd_word;
  logic use_sample;
  logic fault_c;
  logic [ADDR_W-1:0] idx_c;

  assign bus_take = hsel && hready && (htrans == index_addr_pkg::HTRANS_NONSEQ ||
    htrans == index_addr_pkg::HTRANS_SEQ);

  // ==========================================================
  // index registers
  // iteration index has no bus path at all
  mod_index_counter #(
    .WIDTH(ADDR_W)
  ) u_iteration (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .step(index_ctl.iter_step),
    .load(1'b0),
    .load_value('0),
    .modulus(st_q.iter_mod),
    .count(iter_cnt)
  );

  mod_index_counter #(
    .WIDTH(ADDR_W)
  ) u_sample (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .step(index_ctl.sample_start && !st_q.ptr_mode),
    .load(index_ctl.sample_load && st_q.ptr_mode),
    .load_value(result_bus[ADDR_W-1:0]),
    .modulus(st_q.ptr_mode ? '0 : st_q.sample_mod),
    .count(sample_cnt)
  );

  // ==========================================================
  // address formation
  always_comb begin
    use_sample = (ucode.sel == index_addr_pkg::SEL_SAMPLE);
    if (ucode.shared) begin
      use_sample = !ucode.in_subprog;
    end
    fault_c = ucode.valid && ucode.indexed && ucode.shared && use_sample && st_q.ptr_mode;
    idx_c = use_sample ? sample_cnt : iter_cnt;
    if (fault_c) begin
      idx_c = '0;
    end
  end

  // ==========================================================
  // read data for the address phase
  always_comb begin
    rd_word = '0;
    if (haddr == index_addr_pkg::STATUS_OFS) begin
      rd_word[index_addr_pkg::STATUS_SAMPLE_LSB +: ADDR_W] = sample_cnt;
      rd_word[index_addr_pkg::STATUS_PTR_MODE_BIT] = st_q.ptr_mode;
    end else begin
      unique case (decode_reg(haddr))
        index_addr_pkg::REG_CTRL: rd_word[index_addr_pkg::CTRL_PTR_MODE_BIT] = st_q.ptr_mode;
        index_addr_pkg::REG_ITER_MOD: rd_word[ADDR_W-1:0] = st_q.iter_mod;
        index_addr_pkg::REG_SAMPLE_MOD: rd_word[ADDR_W-1:0] = st_q.sample_mod;
        index_addr_pkg::REG_NONE: rd_word = '0;
      endcase
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.hreadyout = 1'b1;
    st_d.hresp = index_addr_pkg::HRESP_OKAY;
    // data phase of a write
    if (st_q.wr_pend) begin
      unique case (st_q.wr_sel)
        index_addr_pkg::REG_CTRL: st_d.ptr_mode = hwdata[index_addr_pkg::CTRL_PTR_MODE_BIT];
        index_addr_pkg::REG_ITER_MOD: st_d.iter_mod = hwdata[ADDR_W-1:0];
        index_addr_pkg::REG_SAMPLE_MOD: st_d.sample_mod = hwdata[ADDR_W-1:0];
        index_addr_pkg::REG_NONE: st_d.wr_pend = 1'b0;
      endcase
    end
    st_d.wr_pend = bus_take && hwrite;
    st_d.wr_sel = decode_reg(haddr);
    if (bus_take && !hwrite) begin
      st_d.hrdata = rd_word;
    end
    // address output
    st_d.mem_valid = ucode.valid;
    st_d.index_fault = fault_c;
    if (ucode.valid) begin
      if (ucode.indexed) begin
        st_d.mem_addr = ADDR_W'(ucode.addr_field + idx_c);
      end else begin
        st_d.mem_addr = ucode.addr_field;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q.ptr_mode <= index_addr_pkg::CTRL_PTR_MODE_RST;
      st_q.iter_mod <= index_addr_pkg::MOD_RST;
      st_q.sample_mod <= index_addr_pkg::MOD_RST;
      st_q.wr_pend <= 1'b0;
      st_q.wr_sel <= index_addr_pkg::REG_NONE;
      st_q.hrdata <= '0;
      st_q.hreadyout <= 1'b1;
      st_q.hresp <= index_addr_pkg::HRESP_OKAY;
      st_q.mem_addr <= '0;
      st_q.mem_valid <= 1'b0;
      st_q.index_fault <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign hreadyout = st_q.hreadyout;
  assign hrdata = st_q.hrdata;
  assign hresp = st_q.hresp;
  assign mem_addr = st_q.mem_addr;
  assign mem_addr_valid = st_q.mem_valid;
  assign index_fault = st_q.index_fault;
  assign iteration_index = iter_cnt;
  assign sample_index = sample_cnt;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence s_direct_word;
    clk_en && ucode.valid && !ucode.indexed;
  endsequence

  sequence s_iter_indexed;
    clk_en && ucode.valid && ucode.indexed && !ucode.shared && ucode.sel == index_addr_pkg::SEL_ITERATION;
  endsequence

  a_direct_addr_pass: assert property (s_direct_word |=> mem_addr == $past(ucode.addr_field) && mem_addr_valid)
    else $error("direct address altered");

  a_indexed_addr_sum: assert property (s_iter_indexed |=>
    mem_addr == ADDR_W'($past(ucode.addr_field) + $past(iteration_index)))
    else $error("indexed address is not field plus iteration index");

  a_iter_step_once: assert property (clk_en && index_ctl.iter_step &&
    iteration_index != ADDR_W'(st_q.iter_mod - 1'b1) |=> iteration_index == ADDR_W'($past(iteration_index) + 1'b1))
    else $error("iteration index did not advance by one");

  a_iter_wrap_mod: assert property (clk_en && index_ctl.iter_step &&
    iteration_index == ADDR_W'(st_q.iter_mod - 1'b1) |=> iteration_index == '0)
    else $error("iteration index did not wrap at modulus");

  a_iter_no_bus: assert property (clk_en && !index_ctl.iter_step |=> $stable(iteration_index))
    else $error("iteration index changed without an iteration");

  a_sample_wrap_mod: assert property (clk_en && !st_q.ptr_mode && index_ctl.sample_start &&
    sample_index == ADDR_W'(st_q.sample_mod - 1'b1) |=> sample_index == '0)
    else $error("sample index did not wrap at modulus");

  a_sample_period_step: assert property (clk_en && !st_q.ptr_mode && index_ctl.sample_start &&
    sample_index != ADDR_W'(st_q.sample_mod - 1'b1) |=> sample_index == ADDR_W'($past(sample_index) + 1'b1))
    else $error("sample index did not step at period start");

  a_pointer_load_hold: assert property (clk_en && st_q.ptr_mode |=>
    sample_index == ($past(index_ctl.sample_load) ? $past(result_bus[ADDR_W-1:0]) : $past(sample_index)))
    else $error("pointer-mode sample index neither loaded nor held");

  a_shared_sub_iter: assert property (clk_en && ucode.valid && ucode.indexed && ucode.shared && ucode.in_subprog
    |=> mem_addr == ADDR_W'($past(ucode.addr_field) + $past(iteration_index)) && !index_fault)
    else $error("shared array in sub-program not indexed by iteration index");

  a_pointer_shared_block: assert property (clk_en && st_q.ptr_mode && ucode.valid && ucode.indexed &&
    ucode.shared && !ucode.in_subprog |=> index_fault && mem_addr == $past(ucode.addr_field))
    else $error("sample index used on shared array in pointer mode");

  a_reset_clears_index: assert property (disable iff (1'b0) reset |=> iteration_index == '0 && sample_index == '0)
    else $error("index counters not cleared by reset");

  // ==========================================================
  // register slave, clock-enable freeze and further address forms
  sequence s_reg_write(logic [31:0] ofs);
    clk_en && bus_take && hwrite && haddr == ofs;
  endsequence

  sequence s_reg_read(logic [31:0] ofs);
    clk_en && bus_take && !hwrite && haddr == ofs;
  endsequence

  sequence s_sample_indexed;
    clk_en && ucode.valid && ucode.indexed && !ucode.shared && ucode.sel == index_addr_pkg::SEL_SAMPLE;
  endsequence

  a_write_iter_mod: assert property (s_reg_write(index_addr_pkg::ITER_MOD_OFS) ##1 clk_en |=>
    st_q.iter_mod == $past(hwdata[ADDR_W-1:0]))
    else $error("iteration modulus write did not land");

  a_write_sample_mod: assert property (s_reg_write(index_addr_pkg::SAMPLE_MOD_OFS) ##1 clk_en |=>
    st_q.sample_mod == $past(hwdata[ADDR_W-1:0]))
    else $error("sample modulus write did not land");

  a_write_ptr_mode: assert property (s_reg_write(index_addr_pkg::CTRL_OFS) ##1 clk_en |=>
    st_q.ptr_mode == $past(hwdata[index_addr_pkg::CTRL_PTR_MODE_BIT]))
    else $error("mode write did not land");

  a_read_iter_mod: assert property (s_reg_read(index_addr_pkg::ITER_MOD_OFS) |=>
    hrdata[ADDR_W-1:0] == $past(st_q.iter_mod) && hrdata[31:ADDR_W] == '0)
    else $error("iteration modulus read wrong");

  a_read_ctrl_reg: assert property (s_reg_read(index_addr_pkg::CTRL_OFS) |=>
    hrdata[index_addr_pkg::CTRL_PTR_MODE_BIT] == $past(st_q.ptr_mode))
    else $error("mode read wrong");

  a_read_status_word: assert property (s_reg_read(index_addr_pkg::STATUS_OFS) |=>
    hrdata[index_addr_pkg::STATUS_SAMPLE_LSB +: ADDR_W] == $past(sample_index) &&
    hrdata[index_addr_pkg::STATUS_PTR_MODE_BIT] == $past(st_q.ptr_mode) &&
    hrdata[31:index_addr_pkg::STATUS_PTR_MODE_BIT+1] == '0)
    else $error("status read wrong");

  a_freeze_state: assert property (!clk_en |=> $stable(mem_addr) && $stable(mem_addr_valid) &&
    $stable(index_fault) && $stable(iteration_index) && $stable(sample_index) && $stable(hrdata))
    else $error("state moved while clock enable low");

  a_invalid_word_hold: assert property (clk_en && !ucode.valid |=> !mem_addr_valid && $stable(mem_addr))
    else $error("invalid word changed the address");

  a_sample_indexed_sum: assert property (s_sample_indexed |=>
    mem_addr == ADDR_W'($past(ucode.addr_field) + $past(sample_index)) && !index_fault)
    else $error("indexed address is not field plus sample index");

  a_shared_main_sample: assert property (clk_en && !st_q.ptr_mode && ucode.valid && ucode.indexed &&
    ucode.shared && !ucode.in_subprog |=> mem_addr == ADDR_W'($past(ucode.addr_field) + $past(sample_index)))
    else $error("shared array in main program not indexed by sample index");

  a_counter_no_fault: assert property (clk_en && !st_q.ptr_mode |=> !index_fault)
    else $error("fault raised in counter mode");

  a_fault_with_valid: assert property (index_fault |-> mem_addr_valid)
    else $error("fault without a valid word");

endmodule

// file: tb/seq_partner.sv
// holds: model of the sequencer and datapath result bus facing the address unit
// assumes: bench sets requests after a rising edge; one clock, sync reset
`timescale 1ns/1ns
module seq_partner (
  input wire logic sys_clk,
  input wire logic reset,
  input wire index_addr_pkg::ucode_t req_ucode,
  input wire index_addr_pkg::index_ctl_t req_ctl,
  input wire logic [15:0] req_result,
  output index_addr_pkg::ucode_t ucode,
  output index_addr_pkg::index_ctl_t index_ctl,
  output logic [15:0] result_bus
);
  // ==========================================================
  // drive word and strobes every cycle
  logic [15:0] last_q;
  assign ucode = req_ucode;
  assign index_ctl = req_ctl;
  // bus shows the inverse of the last load when not loading
  assign result_bus = req_ctl.sample_load ? req_result : ~last_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      last_q <= 16'h0000;
    end else if (req_ctl.sample_load) begin
      last_q <= req_result;
    end
  end
endmodule

// file: tb/tb_top.sv
// holds: self-checking bench of the indexed address generator
// assumes: design and package under hdl/, partner model beside this file
`timescale 1ns/1ns
module tb_top;
  logic sys_clk, reset, clk_en, hsel, hwrite, hreadyout, hresp, index_fault;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [6:0] mem_addr, iteration_index, sample_index;
  logic mem_addr_valid, run_q;
  logic chk_on = 1'b0;
  index_addr_pkg::ucode_t req_u, ucode;
  index_addr_pkg::index_ctl_t req_c, index_ctl;
  logic [15:0] req_r, result_bus, lfsr_q;
  logic [6:0] it_m, sm_m, ea_m, idx;
  logic [6:0] imod_m = 7'h00;
  logic [6:0] smod_m = 7'h00;
  logic ptr_m = 1'b0;
  logic ev_m, ef_m, s;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int k;
  logic [6:0] cfg_im [4] = '{7'h01, 7'h05, 7'h09, 7'h00};
  logic [6:0] cfg_sm [4] = '{7'h01, 7'h03, 7'h07, 7'h00};
  logic cfg_pm [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

  indexed_address_generator u_indexed_address_generator (.sys_clk(sys_clk), .reset(reset),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ucode(ucode), .index_ctl(index_ctl), .result_bus(result_bus), .mem_addr(mem_addr),
    .mem_addr_valid(mem_addr_valid), .index_fault(index_fault),
    .iteration_index(iteration_index), .sample_index(sample_index));
  seq_partner u_seq_partner (.sys_clk(sys_clk), .reset(reset), .req_ucode(req_u), .req_ctl(req_c),
    .req_result(req_r), .ucode(ucode), .index_ctl(index_ctl), .result_bus(result_bus));

  // ==========================================================
  // helpers
  function automatic logic [6:0] step(input logic [6:0] c, input logic [6:0] m);
    step = (c == m - 7'h01) ? 7'h00 : c + 7'h01;
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (!ok) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= index_addr_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r === e && hresp === index_addr_pkg::HRESP_OKAY && hreadyout === 1'b1, "register read");
  endtask
  task automatic summarize;
    $display("compares %0d errors %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, timeout, random stimulus
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      summarize;
    end
  end
  always @(posedge sys_clk) begin
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      lfsr_q = lfsr(lfsr_q);
      r = {r[30:0], lfsr_q[0]};
    end
    clk_en <= run_q ? |r[31:29] : 1'b1;
    req_u <= run_q ? index_addr_pkg::ucode_t'({r[0] | r[1], r[5:2], r[12:6]}) : '0;
    req_c <= run_q ? index_addr_pkg::index_ctl_t'({r[13], r[14] & r[15], ptr_m & r[16]}) : '0;
    req_r <= r[28:13];
  end

  // ==========================================================
  // reference model and per-cycle comparison
  always @(posedge sys_clk) begin
    if (reset) begin
      it_m = 7'h00; sm_m = 7'h00; ev_m = 1'b0;
      chk_on = 1'b1;
    end else if (clk_en) begin
      ev_m = ucode.valid;
      ef_m = 1'b0;
      s = ucode.shared ? ~ucode.in_subprog : (ucode.sel == index_addr_pkg::SEL_SAMPLE);
      idx = !ucode.indexed ? 7'h00 : (s ? sm_m : it_m);
      if (ucode.indexed && ucode.shared && s && ptr_m) begin
        idx = 7'h00;
        ef_m = 1'b1;
      end
      if (ucode.valid) ea_m = ucode.addr_field + idx;
      if (index_ctl.iter_step) it_m = step(it_m, imod_m);
      if (ptr_m && index_ctl.sample_load) sm_m = result_bus[6:0];
      if (!ptr_m && index_ctl.sample_start) sm_m = step(sm_m, smod_m);
    end
  end
  always @(negedge sys_clk) begin
    if (chk_on) begin
      check(mem_addr_valid === ev_m, "address valid");
      if (ev_m) check(mem_addr === ea_m, "memory address");
      if (ev_m) check(index_fault === ef_m, "shared pointer fault");
      check(iteration_index === it_m, "iteration index");
      check(sample_index === sm_m, "sample index");
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, run_q} = '0;
    reset = 1'b1;
    lfsr_q = 16'd13059;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd_chk(index_addr_pkg::CTRL_OFS, 32'h0);
    rd_chk(index_addr_pkg::ITER_MOD_OFS, 32'h0);
    rd_chk(index_addr_pkg::STATUS_OFS, 32'h0);
    rd_chk(32'h10, 32'h0);
    for (k = 0; k < 4; k++) begin
      bus(1'b1, index_addr_pkg::ITER_MOD_OFS, {25'h0, cfg_im[k]}, v);
      bus(1'b1, index_addr_pkg::SAMPLE_MOD_OFS, {25'h0, cfg_sm[k]}, v);
      bus(1'b1, index_addr_pkg::CTRL_OFS, {31'h0, cfg_pm[k]}, v);
      bus(1'b1, index_addr_pkg::STATUS_OFS, 32'hffff_ffff, v);
      bus(1'b1, 32'h20, 32'hffff_ffff, v);
      imod_m = cfg_im[k];
      smod_m = cfg_sm[k];
      ptr_m = cfg_pm[k];
      rd_chk(index_addr_pkg::ITER_MOD_OFS, {25'h0, cfg_im[k]});
      rd_chk(index_addr_pkg::SAMPLE_MOD_OFS, {25'h0, cfg_sm[k]});
      rd_chk(index_addr_pkg::CTRL_OFS, {31'h0, cfg_pm[k]});
      run_q <= 1'b1;
      repeat (200) @(posedge sys_clk);
      if (k == 3) reset <= 1'b1;
      @(posedge sys_clk);
      reset <= 1'b0;
      repeat (200) @(posedge sys_clk);
      run_q <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd_chk(index_addr_pkg::STATUS_OFS, {23'h0, ptr_m, 1'b0, sm_m});
    end
    rd_chk(32'h10, 32'h0);
    summarize;
  end
endmodule
